// ---- common/clk_synth_pkg.sv ----
// package: register map, field layout and reset words for the clock synthesizer control
package clk_synth_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address = 4 * index is not used: plain port)
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_PRESCALE_POSTDIV = 4'h0;  // prescale and post-divide
    localparam logic [3:0] ADDR_M_COUNT          = 4'h1;  // feedback count minus two
    localparam logic [3:0] ADDR_N_COUNT          = 4'h2;  // reference count minus two, commits
    localparam logic [3:0] ADDR_SELECT_POINTER   = 4'h3;  // synthesizer pointer
    localparam logic [3:0] ADDR_MISC_OUTPUT      = 4'h4;  // pixel clock select bits
    localparam logic [3:0] ADDR_MEM_WORD_STATUS  = 4'h5;  // committed memory word, low byte
    localparam logic [3:0] ADDR_PIX_WORD_STATUS  = 4'h6;  // committed pixel word, low byte
    localparam logic [3:0] ADDR_COMMIT_STATUS    = 4'h7;  // commit counters and last target

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int PRESCALE_BIT     = 0;  // 0: divide by one, 1: divide by four
    localparam int POSTDIV_LSB      = 1;  // post-divide code bits 3:1
    localparam int POINTER_BIT      = 5;  // 0: memory synthesizer, 1: pixel synthesizer
    localparam int CLK_SEL_LSB      = 2;  // misc output bits 3:2

    // ----------------------------------------------------------------
    // divisor word layout, 18 bits: {post[2:0], prescale, n[6:0], m[6:0]}
    // ----------------------------------------------------------------
    localparam int WORD_W           = 18;
    localparam int COUNT_W          = 7;
    localparam int EFF_W            = 8;   // effective M or N after adding two
    localparam logic [7:0] COUNT_OFFSET = 8'h02;
    localparam logic [2:0] POSTDIV_MAX  = 3'h5;  // ratio 32

    // memory synthesizer reset: ref 14.31818, prescale 1, M 88, N 42 -> 120 MHz vco, /2
    localparam logic [2:0] MEM_RST_POST     = 3'h1;
    localparam logic       MEM_RST_PRESCALE = 1'b0;
    localparam logic [6:0] MEM_RST_M        = 7'h56;  // 88 - 2
    localparam logic [6:0] MEM_RST_N        = 7'h28;  // 42 - 2
    // pixel synthesizer reset: 25.175 MHz example word
    localparam logic [2:0] PIX_RST_POST     = 3'h1;
    localparam logic       PIX_RST_PRESCALE = 1'b0;
    localparam logic [6:0] PIX_RST_M        = 7'h4E;
    localparam logic [6:0] PIX_RST_N        = 7'h59;

    // pixel clock select codes
    typedef enum logic [1:0] {
        SEL_VGA_ZERO = 2'b00,
        SEL_VGA_ONE  = 2'b01,
        SEL_PROG     = 2'b10,
        SEL_RESERVED = 2'b11
    } clk_sel_t;

endpackage : clk_synth_pkg

// ---- src/dual_pll_clock_synth_control.sv ----
// dual synthesizer divisor-word control with pixel clock entry selection
//
// Summary of operation
// - eighteen-bit word per synthesizer, shared register set
// - pointer bit steers writes to memory/pixel synthesizer
// - bit zero picks reference prescale one or four
// - effective M is stored count plus two
// - effective N is stored count plus two
// - post-divide code gives ratios one to thirty-two
// - vco is ref*4*M over prescale*N
// - writing N count commits the whole word
// - post-divide change applies at commit, unsynchronised
// - memory synthesizer resets to 60 MHz word
// - entries zero and one fixed, two programmable
// - misc output bits 3:2 pick pixel entry
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module dual_pll_clock_synth_control
    import clk_synth_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [7:0]      reg_rdata,
    // memory synthesizer settings towards the analog loop
    output logic            mem_prescale_select,
    output logic [7:0]      mem_m_eff,
    output logic [7:0]      mem_n_eff,
    output logic [2:0]      mem_post_code,
    output logic            mem_load,
    // pixel synthesizer settings towards the analog loop
    output logic            pix_prescale_select,
    output logic [7:0]      pix_m_eff,
    output logic [7:0]      pix_n_eff,
    output logic [2:0]      pix_post_code,
    output logic            pix_load,
    // pixel clock mux select
    output logic [1:0]      pixel_clock_sel,
    output logic            pixel_sel_reserved
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // stored count to effective divider value
    function automatic logic [7:0] eff_count(input logic [6:0] stored);
        eff_count = {1'b0, stored} + COUNT_OFFSET;
    endfunction : eff_count

    // word packing {post, prescale, n, m}
    function automatic logic [17:0] pack_word(input logic [7:0] pp, input logic [6:0] m,
                                              input logic [6:0] n);
        pack_word = {pp[POSTDIV_LSB +: 3], pp[PRESCALE_BIT], n, m};
    endfunction : pack_word

    // ----------------------------------------------------------------
    // staging registers (shared by both synthesizers)
    // ----------------------------------------------------------------
    logic [7:0]  pp_ff,   nxt_pp;     // prescale and post-divide staging
    logic [6:0]  m_ff,    nxt_m;      // M count staging
    logic [6:0]  n_ff,    nxt_n;      // last N count written
    logic        ptr_ff,  nxt_ptr;    // synthesizer pointer
    logic [1:0]  sel_ff,  nxt_sel;    // misc output clock select

    wire wr_pp  = reg_write && (reg_addr == ADDR_PRESCALE_POSTDIV);
    wire wr_m   = reg_write && (reg_addr == ADDR_M_COUNT);
    wire wr_n   = reg_write && (reg_addr == ADDR_N_COUNT);
    wire wr_ptr = reg_write && (reg_addr == ADDR_SELECT_POINTER);
    wire wr_sel = reg_write && (reg_addr == ADDR_MISC_OUTPUT);

    // next values for staging registers
    always_comb begin
        nxt_pp  = wr_pp  ? reg_wdata : pp_ff;
        nxt_m   = wr_m   ? reg_wdata[6:0] : m_ff;
        nxt_n   = wr_n   ? reg_wdata[6:0] : n_ff;
        nxt_ptr = wr_ptr ? reg_wdata[POINTER_BIT] : ptr_ff;
        nxt_sel = wr_sel ? reg_wdata[CLK_SEL_LSB +: 2] : sel_ff;
    end

    // registering, reset values leave the pointer on the memory synthesizer
    always_ff @(posedge clock) begin
        if (rst) begin
            pp_ff  <= 8'h00;
            m_ff   <= 7'h00;
            n_ff   <= 7'h00;
            ptr_ff <= 1'b0;
            sel_ff <= 2'h0;
        end else begin
            pp_ff  <= nxt_pp;
            m_ff   <= nxt_m;
            n_ff   <= nxt_n;
            ptr_ff <= nxt_ptr;
            sel_ff <= nxt_sel;
        end
    end

    // ----------------------------------------------------------------
    // committed words
    // ----------------------------------------------------------------
    logic [17:0] mem_word_ff, nxt_mem_word;   // active memory word
    logic [17:0] pix_word_ff, nxt_pix_word;   // active pixel word
    logic        mem_load_ff, nxt_mem_load;   // one-cycle load pulse
    logic        pix_load_ff, nxt_pix_load;
    logic [2:0]  mem_cnt_ff,  nxt_mem_cnt;    // commit counters, wrap
    logic [2:0]  pix_cnt_ff,  nxt_pix_cnt;
    logic        last_ff,     nxt_last;       // target of last commit
    logic [17:0] commit_word;

    // the N write itself carries the final field, so the word is built from the bus
    // data rather than n_ff; the loop starts seeking in the cycle after the N write
    always_comb begin
        commit_word  = pack_word(pp_ff, m_ff, reg_wdata[6:0]);
        nxt_mem_word = mem_word_ff;
        nxt_pix_word = pix_word_ff;
        nxt_mem_load = 1'b0;
        nxt_pix_load = 1'b0;
        nxt_mem_cnt  = mem_cnt_ff;
        nxt_pix_cnt  = pix_cnt_ff;
        nxt_last     = last_ff;
        if (wr_n) begin
            nxt_last = ptr_ff;
            if (ptr_ff) begin
                nxt_pix_word = commit_word;
                nxt_pix_load = 1'b1;
                nxt_pix_cnt  = pix_cnt_ff + 3'h1;
            end else begin
                nxt_mem_word = commit_word;
                nxt_mem_load = 1'b1;
                nxt_mem_cnt  = mem_cnt_ff + 3'h1;
            end
        end
    end

    // committed word registers, memory word defaults to 60 MHz
    always_ff @(posedge clock) begin
        if (rst) begin
            mem_word_ff <= {MEM_RST_POST, MEM_RST_PRESCALE, MEM_RST_N, MEM_RST_M};
            pix_word_ff <= {PIX_RST_POST, PIX_RST_PRESCALE, PIX_RST_N, PIX_RST_M};
            mem_load_ff <= 1'b0;
            pix_load_ff <= 1'b0;
            mem_cnt_ff  <= 3'h0;
            pix_cnt_ff  <= 3'h0;
            last_ff     <= 1'b0;
        end else begin
            mem_word_ff <= nxt_mem_word;
            pix_word_ff <= nxt_pix_word;
            mem_load_ff <= nxt_mem_load;
            pix_load_ff <= nxt_pix_load;
            mem_cnt_ff  <= nxt_mem_cnt;
            pix_cnt_ff  <= nxt_pix_cnt;
            last_ff     <= nxt_last;
        end
    end

    // ----------------------------------------------------------------
    // decoded loop settings, all registered
    // ----------------------------------------------------------------
    logic [7:0]  mem_m_ff, nxt_mem_m, mem_n_ff, nxt_mem_n;
    logic [7:0]  pix_m_ff, nxt_pix_m, pix_n_ff, nxt_pix_n;
    logic [2:0]  mem_p_ff, nxt_mem_p, pix_p_ff, nxt_pix_p;
    logic        mem_ps_ff, nxt_mem_ps, pix_ps_ff, nxt_pix_ps;

    // decode next committed words; codes above 101 are clamped to ratio 32 since
    // the divider has no larger stage. post code moves with the word, no sync
    always_comb begin
        nxt_mem_m  = eff_count(nxt_mem_word[6:0]);
        nxt_mem_n  = eff_count(nxt_mem_word[13:7]);
        nxt_mem_ps = nxt_mem_word[14];
        nxt_mem_p  = (nxt_mem_word[17:15] > POSTDIV_MAX) ? POSTDIV_MAX
                                                         : nxt_mem_word[17:15];
        nxt_pix_m  = eff_count(nxt_pix_word[6:0]);
        nxt_pix_n  = eff_count(nxt_pix_word[13:7]);
        nxt_pix_ps = nxt_pix_word[14];
        nxt_pix_p  = (nxt_pix_word[17:15] > POSTDIV_MAX) ? POSTDIV_MAX
                                                         : nxt_pix_word[17:15];
    end

    // registered loop settings; the analog loop computes ref*4*M/(ps*N)
    always_ff @(posedge clock) begin
        if (rst) begin
            mem_m_ff  <= eff_count(MEM_RST_M);
            mem_n_ff  <= eff_count(MEM_RST_N);
            mem_ps_ff <= MEM_RST_PRESCALE;
            mem_p_ff  <= MEM_RST_POST;
            pix_m_ff  <= eff_count(PIX_RST_M);
            pix_n_ff  <= eff_count(PIX_RST_N);
            pix_ps_ff <= PIX_RST_PRESCALE;
            pix_p_ff  <= PIX_RST_POST;
        end else begin
            mem_m_ff  <= nxt_mem_m;
            mem_n_ff  <= nxt_mem_n;
            mem_ps_ff <= nxt_mem_ps;
            mem_p_ff  <= nxt_mem_p;
            pix_m_ff  <= nxt_pix_m;
            pix_n_ff  <= nxt_pix_n;
            pix_ps_ff <= nxt_pix_ps;
            pix_p_ff  <= nxt_pix_p;
        end
    end

    // ----------------------------------------------------------------
    // pixel clock entry select
    // ----------------------------------------------------------------
    logic [1:0] vsel_ff, nxt_vsel;   // mux code
    logic       vres_ff, nxt_vres;   // reserved code seen

    // reserved code holds the programmable entry so the pixel clock never stops
    always_comb begin
        nxt_vres = 1'b0;
        unique case (clk_sel_t'(nxt_sel))
            SEL_VGA_ZERO: nxt_vsel = SEL_VGA_ZERO;
            SEL_VGA_ONE:  nxt_vsel = SEL_VGA_ONE;
            SEL_PROG:     nxt_vsel = SEL_PROG;
            SEL_RESERVED: begin
                nxt_vsel = SEL_PROG;
                nxt_vres = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            vsel_ff <= SEL_VGA_ZERO;
            vres_ff <= 1'b0;
        end else begin
            vsel_ff <= nxt_vsel;
            vres_ff <= nxt_vres;
        end
    end

    // ----------------------------------------------------------------
    // read port, data one cycle after the strobe
    // ----------------------------------------------------------------
    logic [7:0] rdata_ff, nxt_rdata;

    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                ADDR_PRESCALE_POSTDIV: nxt_rdata = pp_ff;
                ADDR_M_COUNT:          nxt_rdata = {1'b0, m_ff};
                ADDR_N_COUNT:          nxt_rdata = {1'b0, n_ff};
                ADDR_SELECT_POINTER:   nxt_rdata = 8'(ptr_ff) << POINTER_BIT;
                ADDR_MISC_OUTPUT:      nxt_rdata = {4'h0, sel_ff, 2'h0};
                ADDR_MEM_WORD_STATUS:  nxt_rdata = mem_word_ff[7:0];
                ADDR_PIX_WORD_STATUS:  nxt_rdata = pix_word_ff[7:0];
                ADDR_COMMIT_STATUS:    nxt_rdata = {last_ff, pix_cnt_ff, 1'b0, mem_cnt_ff};
                default:               nxt_rdata = 8'h00;  // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ----------------------------------------------------------------
    // outputs straight from flip-flops
    // ----------------------------------------------------------------
    assign reg_rdata           = rdata_ff;
    assign mem_prescale_select = mem_ps_ff;
    assign mem_m_eff           = mem_m_ff;
    assign mem_n_eff           = mem_n_ff;
    assign mem_post_code       = mem_p_ff;
    assign mem_load            = mem_load_ff;
    assign pix_prescale_select = pix_ps_ff;
    assign pix_m_eff           = pix_m_ff;
    assign pix_n_eff           = pix_n_ff;
    assign pix_post_code       = pix_p_ff;
    assign pix_load            = pix_load_ff;
    assign pixel_clock_sel     = vsel_ff;
    assign pixel_sel_reserved  = vres_ff;

endmodule : dual_pll_clock_synth_control

`default_nettype wire

// ---- tb/clk_synth_asserts.sv ----
// checker: port-level properties of the dual synthesizer control
`timescale 1ns/100ps
`default_nettype none
module clk_synth_asserts
    import clk_synth_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       mem_prescale_select,
    input wire logic [7:0] mem_m_eff,
    input wire logic [7:0] mem_n_eff,
    input wire logic [2:0] mem_post_code,
    input wire logic       mem_load,
    input wire logic       pix_prescale_select,
    input wire logic [7:0] pix_m_eff,
    input wire logic [7:0] pix_n_eff,
    input wire logic [2:0] pix_post_code,
    input wire logic       pix_load,
    input wire logic [1:0] pixel_clock_sel,
    input wire logic       pixel_sel_reserved
);
    // ----------------------------------------------------------------
    // pointer mirror: commits are judged against the last pointer write
    // ----------------------------------------------------------------
    logic ptr_ff;   // copy of the synthesizer pointer
    logic nxt_ptr;  // next pointer copy
    logic n_wr;     // write to the committing count register
    assign n_wr = reg_write && (reg_addr == ADDR_N_COUNT);
    always_comb begin
        nxt_ptr = ptr_ff;
        if (rst) begin
            nxt_ptr = 1'b0;
        end else if (reg_write && (reg_addr == ADDR_SELECT_POINTER)) begin
            nxt_ptr = reg_wdata[POINTER_BIT];
        end
    end
    always_ff @(posedge clock) begin
        ptr_ff <= nxt_ptr;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    mem_commit_a: assert property (n_wr && !ptr_ff |=> mem_load && !pix_load)
        else $error("memory commit missing");
    pix_commit_a: assert property (n_wr && ptr_ff |=> pix_load && !mem_load)
        else $error("pixel commit missing");
    load_cause_a: assert property (mem_load || pix_load |-> $past(n_wr))
        else $error("load without count write");
    n_count_a: assert property (mem_load |-> mem_n_eff == {1'b0, $past(reg_wdata[6:0])} + 8'h02)
        else $error("effective divider wrong");
    word_hold_a: assert property (!pix_load |-> $stable(pix_m_eff) && $stable(pix_n_eff))
        else $error("pixel word moved without commit");
    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    // the reserved code is shown as the programmable entry, so map it before comparing
    clk_sel_a: assert property (reg_write && reg_addr == ADDR_MISC_OUTPUT |=>
        pixel_clock_sel == (($past(reg_wdata[3:2]) == 2'b11) ? 2'b10 : $past(reg_wdata[3:2])))
        else $error("pixel select not taken");
    sel_reserved_a: assert property (reg_write && reg_addr == ADDR_MISC_OUTPUT |=>
        pixel_sel_reserved == ($past(reg_wdata[3:2]) == 2'b11))
        else $error("reserved flag wrong");
    res_prog_a: assert property (pixel_sel_reserved |-> pixel_clock_sel == SEL_PROG)
        else $error("reserved code left programmable entry");
    post_limit_a: assert property (mem_post_code <= POSTDIV_MAX && pix_post_code <= POSTDIV_MAX)
        else $error("post code out of range");
endmodule : clk_synth_asserts
bind dual_pll_clock_synth_control clk_synth_asserts clk_synth_asserts_i (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .mem_prescale_select(mem_prescale_select), .mem_m_eff(mem_m_eff), .mem_n_eff(mem_n_eff),
    .mem_post_code(mem_post_code), .mem_load(mem_load),
    .pix_prescale_select(pix_prescale_select), .pix_m_eff(pix_m_eff), .pix_n_eff(pix_n_eff),
    .pix_post_code(pix_post_code), .pix_load(pix_load),
    .pixel_clock_sel(pixel_clock_sel), .pixel_sel_reserved(pixel_sel_reserved));
`default_nettype wire

// ---- tb/dual_pll_clock_synth_control_test.sv ----
// testbench: random divisor words, select codes and readback against a bench model
`timescale 1ns/100ps
`default_nettype none
module dual_pll_clock_synth_control_test
    import clk_synth_pkg::*;
;
    logic        clock, rst, reg_write, reg_read;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic [6:0]  mc, nc;   // stimulus M and N counts
    logic [2:0]  po;       // stimulus post-divide code
    logic        mem_prescale_select, pix_prescale_select, mem_load, pix_load;
    logic [7:0]  mem_m_eff, mem_n_eff, pix_m_eff, pix_n_eff;
    logic [2:0]  mem_post_code, pix_post_code;
    logic [1:0]  pixel_clock_sel;
    logic        pixel_sel_reserved;
    logic [31:0] lfsr;     // random source
    int          err_total, check_count, k;
    int          exp_m[2], exp_n[2], exp_ps[2], exp_po[2];  // model: 0 memory, 1 pixel
    // ----------------------------------------------------------------
    // design, host and clock
    // ----------------------------------------------------------------
    dual_pll_clock_synth_control dual_pll_clock_synth_control_i (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .mem_prescale_select(mem_prescale_select), .mem_m_eff(mem_m_eff),
        .mem_n_eff(mem_n_eff), .mem_post_code(mem_post_code), .mem_load(mem_load),
        .pix_prescale_select(pix_prescale_select), .pix_m_eff(pix_m_eff),
        .pix_n_eff(pix_n_eff), .pix_post_code(pix_post_code), .pix_load(pix_load),
        .pixel_clock_sel(pixel_clock_sel), .pixel_sel_reserved(pixel_sel_reserved));
    host_model #(.SETTLE_CYCLES(20)) host_model_i (
        .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    function logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task complete_run;
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    // reset for five cycles and reload the model's reset words
    task do_reset;
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        exp_m = '{MEM_RST_M + 2, PIX_RST_M + 2};
        exp_n = '{MEM_RST_N + 2, PIX_RST_N + 2};
        exp_ps = '{MEM_RST_PRESCALE, PIX_RST_PRESCALE};
        exp_po = '{MEM_RST_POST, PIX_RST_POST};
        host_model_i.idle();
        #1 chk(32'(((64'd14318180 * 4 * mem_m_eff / mem_n_eff >> mem_post_code) + 500000) / 1000000), 60);
        chk(pixel_clock_sel, 0);
        @(posedge clock);
    endtask : do_reset
    // compare loads and both loop settings, then realign to an edge
    task cmp_loops(input int lm, input int lp);
        host_model_i.stop();
        #1 chk(mem_load, lm);
        chk(pix_load, lp);
        chk(mem_m_eff, exp_m[0]);
        chk(mem_n_eff, exp_n[0]);
        chk(mem_prescale_select, exp_ps[0]);
        chk(mem_post_code, exp_po[0]);
        chk(pix_m_eff, exp_m[1]);
        chk(pix_n_eff, exp_n[1]);
        chk(pix_prescale_select, exp_ps[1]);
        chk(pix_post_code, exp_po[1]);
        @(posedge clock);
    endtask : cmp_loops
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        err_total = 0;
        check_count = 0;
        lfsr = 32'h6C9F;
        do_reset();
        cmp_loops(0, 0);
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            k = int'(lfsr[0]);
            // vco kept in 48..220 MHz: memory near 57..69 MHz, pixel near 85..98 MHz,
            // so neither loop nor its harmonics come within 0.5% of the other
            nc = lfsr[4] ? {4'h0, lfsr[14:12]} : {2'b01, lfsr[16:12]};
            mc = lfsr[4] ? 7'((k ? 6 : 4) * nc + (k ? 10 : 6) + lfsr[5])
                         : 7'(nc + (k ? (nc >> 1) + 1 : 0) + lfsr[7:5]);
            // memory output stays at or above 28 MHz, above the assumed host bus clock
            po = k ? lfsr[3:1] : {2'b00, lfsr[1]};
            host_model_i.wr(ADDR_SELECT_POINTER, {2'h0, lfsr[0], 5'h00});
            host_model_i.wr(ADDR_PRESCALE_POSTDIV, {4'h0, po, lfsr[4]});
            host_model_i.wr(ADDR_M_COUNT, {1'b0, mc});
            cmp_loops(0, 0);
            host_model_i.wr(ADDR_N_COUNT, {1'b0, nc});
            exp_m[k] = mc + 2;
            exp_n[k] = nc + 2;
            exp_ps[k] = lfsr[4];
            exp_po[k] = (po > 5) ? 5 : po;
            cmp_loops(1 - k, k);
            cmp_loops(0, 0);
            host_model_i.rd(ADDR_M_COUNT, d);
            chk(d, {1'b0, mc});
            host_model_i.settle();
        end
        for (int c = 0; c < 4; c++) begin
            host_model_i.wr(ADDR_MISC_OUTPUT, {4'h0, c[1:0], 2'h0});
            host_model_i.idle();
            #1 chk(pixel_clock_sel, (c == 3) ? 2 : c);
            chk(pixel_sel_reserved, c == 3);
            @(posedge clock);
        end
        host_model_i.wr(4'hF, 8'hFF);
        host_model_i.rd(4'hF, d);
        chk(d, 0);
        cmp_loops(0, 0);
        do_reset();
        cmp_loops(0, 0);
        complete_run();
    end
    // watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        complete_run();
    end
endmodule : dual_pll_clock_synth_control_test
`default_nettype wire

// ---- tb/host_model.sv ----
// host software model: drives the register port
`timescale 1ns/100ps
`default_nettype none
module host_model
    import clk_synth_pkg::*;
#(
    parameter int SETTLE_CYCLES = 20  // stands in for the long settle time
)
(
    input  wire logic       clock,
    output var logic [3:0]  reg_addr,
    output var logic [7:0]  reg_wdata,
    output var logic        reg_write,
    output var logic        reg_read,
    input  wire logic [7:0] reg_rdata
);
    // ----------------------------------------------------------------
    // bus cycles: entered on a rising edge, strobe held one cycle
    // ----------------------------------------------------------------
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    task wr(input logic [3:0] a, input logic [7:0] v);
        reg_write <= 1'b1;
        reg_read <= 1'b0;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
    endtask : wr
    // idle lines are scrambled so stale values never look valid
    task idle;
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        reg_addr <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
        @(posedge clock);
    endtask : idle
    // read data stands only in the cycle after the strobe edge, so take it there
    task rd(input logic [3:0] a, output logic [7:0] v);
        reg_write <= 1'b0;
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clock);
    endtask : rd
    // lower both strobes right after an edge without waiting for the next one
    task stop;
        reg_write <= 1'b0;
        reg_read <= 1'b0;
    endtask : stop
    // quiet gap after each commit while the loops settle
    task settle;
        repeat (SETTLE_CYCLES) @(posedge clock);
    endtask : settle
endmodule : host_model
`default_nettype wire
